// File: verilog/pcc_pkg.sv
package pcc_pkg;
  // Register addresses
  localparam logic [7:0] PCC_ADDR_PORT_DRIVE   = 8'h00;  // Expanded bank F
  localparam logic [3:0] PCC_BANK_PORT_DRIVE   = 4'hf;
  localparam logic [7:0] PCC_ADDR_THIRD_MODE   = 8'hf7;
  localparam logic [7:0] PCC_ADDR_SECOND_MODE  = 8'hf6;
  localparam logic [7:0] PCC_ADDR_THIRD_DATA   = 8'h03;
  localparam logic [7:0] PCC_ADDR_IRQ          = 8'hfa;
  // Port drive configuration fields
  localparam int PCC_PD_COMP_OUT    = 0;
  localparam int PCC_PD_P1_PUSHPULL = 1;
  localparam int PCC_PD_P0_PUSHPULL = 2;
  localparam int PCC_PD_EMI_LO      = 3;
  localparam int PCC_PD_OSC_STD     = 7;
  localparam logic [7:0] PCC_PD_RESET = 8'hfe;
  // Third port mode fields
  localparam int PCC_TM_P2_PUSHPULL = 0;
  localparam int PCC_TM_ANALOG      = 1;
  localparam logic [7:0] PCC_TM_RESET = 8'h00;
  // Second port mode: all inputs
  localparam logic [7:0] PCC_SM_RESET = 8'hff;
  // Third port line indices
  localparam int PCC_L_TIN = 1;
  localparam int PCC_L_C2  = 2;
  localparam int PCC_L_REF = 3;
  localparam int PCC_L_O4  = 4;
  localparam int PCC_L_O5  = 5;
  localparam int PCC_L_O7  = 7;
  // Interrupt request edge select bits
  localparam int PCC_IRQ_E6 = 6;
  localparam int PCC_IRQ_E7 = 7;
  localparam logic [7:0] PCC_IRQ_RESET = 8'h00;
  localparam logic [3:0] PCC_P3_DIR_RESET = 4'hf;  // Upper nibble outputs
  typedef enum logic [1:0] {
    PCC_RUN  = 2'b00,
    PCC_HALT = 2'b01,
    PCC_STOP = 2'b10
  } pcc_power_type;
endpackage

// File: verilog/pcc_edge.sv
`timescale 1ns/1ps
// Edge detector with selectable sense; out pulses one cycle.
module pcc_edge
  import pcc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic level,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      pulse
);
  logic prev;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prev  <= 1'b0;
      pulse <= 1'b0;
    end else begin
      prev  <= level;
      pulse <= (rise_en & level & ~prev) | (fall_en & ~level & prev);
    end
  end
endmodule

// File: verilog/pcc_ctrl.sv
`timescale 1ns/1ps
// How it works
// RQ1: Full reset makes every second-port bit an input with open-drain drive.
// RQ2: Watchdog timeout during stop recovery is no full reset; registers keep values.
// RQ3: Full reset disables third-port special functions; low nibble in, high nibble out.
// RQ4: Mode bit 1 selects analog; lines 1,2 compare against line 3 reference.
// RQ5: Drive-config bit D0 routes comparator results onto output lines 4, 5, 7.
// RQ6: In analog mode line 3 raises no interrupt; only digital mode does.
// RQ7: Comparator interrupts edge-selectable through interrupt request bits 6 and 7.
// RQ8: D7=0,D6=0 low second result interrupts; D7=1,D6=0 both lines interrupt.
// RQ9: Comparator high when input exceeds reference; data read bits D1, D2.
// RQ10: Routing leaves stored bits unchanged; deselecting restores stored values on pins.
// RQ11: Both comparators disabled in STOP mode.
// RQ12: Lines 1-3 recover from stop only in digital mode.
// RQ13: Analog mode selected at stop entry survives stop-recovery reset.
// RQ14: In HALT, analog comparators keep running and interrupting.
// RQ15: Line 1 serves as timer input in both modes, compared in analog.
// RQ16: Third-port mode bit D0: second port open-drain when 0, push-pull when 1.
// RQ17: Drive config is write-only at address 00h of expanded bank F.
// RQ18: Drive config D1: first port open-drain 0, push-pull 1, resets 1.
// RQ19: Drive config D2: port zero open-drain 0, push-pull 1, resets 1.
// RQ20: D3-D6 low-emission when 0 for ports 0-3; each resets 1.
// RQ21: D7 oscillator standard when 1, low-noise when 0; resets 1.
// RQ22: Third-port mode register is write-only at address F7h.
// RQ23: Comparator routing bit resets to 0, pins show stored values.
module pcc_ctrl
  import pcc_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic                 stop_recovery_reset,
  input  wire logic                 wdt_timeout,
  input  wire pcc_pkg::pcc_power_type power_mode,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [3:0]           reg_bank,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic [7:0]           third_port_pins,
  input  wire logic                 comp_one_gt,
  input  wire logic                 comp_two_gt,
  output logic [7:0]                reg_rdata,
  output logic [7:0]                third_port_out,
  output logic [7:0]                third_port_oe_b,
  output logic [7:0]                second_port_oe_b,
  output logic                      second_port_pushpull,
  output logic                      first_port_pushpull,
  output logic                      port_zero_pushpull,
  output logic [3:0]                port_std_drive,
  output logic                      osc_std_drive,
  output logic                      comparator_enable,
  output logic                      analog_mode,
  output logic [3:0]                ext_irq,
  output logic                      stop_wake,
  output logic                      timer_input
);
  import pcc_pkg::*;

  logic [7:0] port_drive_configuration;
  logic [7:0] third_port_mode_register;
  logic [7:0] second_port_mode_register;
  logic [7:0] irq_select;
  logic [7:0] third_port_store;
  logic       first_comparator_result;
  logic       second_comparator_result;
  logic       cmp_rise;
  logic       cmp_fall;
  logic       one_pulse;
  logic       two_pulse;
  logic       ref_pulse;
  logic       dig_pulse1;
  logic       dig_pulse2;
  logic       full_reset;
  logic       analog;
  logic       comp_on;
  logic [7:0] next_pin_out;

  // Stop recovery resets, and watchdog timeouts during it, skip full reset
  assign full_reset = !rst_b && !stop_recovery_reset; // RQ2
  assign analog     = third_port_mode_register[PCC_TM_ANALOG]; // RQ4
  assign comp_on    = analog && (power_mode != PCC_STOP); // RQ11 RQ14

  // Port drive configuration register, write-only
  always_ff @(posedge clock) begin
    if (full_reset) begin
      port_drive_configuration <= PCC_PD_RESET; // RQ18 RQ19 RQ20 RQ21 RQ23
    end else if (rst_b && reg_wr && reg_addr == PCC_ADDR_PORT_DRIVE &&
                 reg_bank == PCC_BANK_PORT_DRIVE) begin
      port_drive_configuration <= reg_wdata; // RQ17
    end
  end

  // Mode registers survive stop-recovery resets
  always_ff @(posedge clock) begin
    if (full_reset) begin
      third_port_mode_register  <= PCC_TM_RESET; // RQ3
      second_port_mode_register <= PCC_SM_RESET; // RQ1
    end else if (rst_b && reg_wr && reg_addr == PCC_ADDR_THIRD_MODE) begin
      third_port_mode_register <= reg_wdata; // RQ22
    end else if (rst_b && reg_wr && reg_addr == PCC_ADDR_SECOND_MODE) begin
      second_port_mode_register <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (full_reset) begin
      irq_select <= PCC_IRQ_RESET;
    end else if (rst_b && reg_wr && reg_addr == PCC_ADDR_IRQ) begin
      irq_select <= reg_wdata;
    end
  end

  // Stored output values, never touched by comparator routing
  always_ff @(posedge clock) begin
    if (full_reset) begin
      third_port_store <= 8'h00;
    end else if (rst_b && reg_wr && reg_addr == PCC_ADDR_THIRD_DATA) begin
      third_port_store <= reg_wdata; // RQ10
    end
  end

  // Comparator results, frozen at low while disabled to save power
  always_ff @(posedge clock) begin
    if (!rst_b || !comp_on) begin
      first_comparator_result  <= 1'b0; // RQ11
      second_comparator_result <= 1'b0;
    end else begin
      first_comparator_result  <= comp_one_gt; // RQ9
      second_comparator_result <= comp_two_gt;
    end
  end

  // Edge select: 00 falling on line 2 only, 10 both lines rising, 01 rise, 11 both
  always_comb begin
    case (irq_select[PCC_IRQ_E7 -: 2])
      2'b00:   begin cmp_rise = 1'b0; cmp_fall = 1'b1; end // RQ8
      2'b10:   begin cmp_rise = 1'b1; cmp_fall = 1'b0; end // RQ7
      2'b01:   begin cmp_rise = 1'b1; cmp_fall = 1'b0; end
      default: begin cmp_rise = 1'b1; cmp_fall = 1'b1; end
    endcase
  end

  pcc_edge u_edge_one (
    .clock   (clock),
    .rst_b   (rst_b),
    .level   (first_comparator_result),
    .rise_en (cmp_rise),
    .fall_en (cmp_fall),
    .pulse   (one_pulse)
  );

  pcc_edge u_edge_two (
    .clock   (clock),
    .rst_b   (rst_b),
    .level   (second_comparator_result),
    .rise_en (cmp_rise),
    .fall_en (cmp_fall),
    .pulse   (two_pulse)
  );

  pcc_edge u_edge_ref (
    .clock   (clock),
    .rst_b   (rst_b),
    .level   (third_port_pins[PCC_L_REF]),
    .rise_en (1'b0),
    .fall_en (1'b1),
    .pulse   (ref_pulse)
  );

  pcc_edge u_edge_d1 (
    .clock   (clock),
    .rst_b   (rst_b),
    .level   (third_port_pins[PCC_L_TIN]),
    .rise_en (1'b0),
    .fall_en (1'b1),
    .pulse   (dig_pulse1)
  );

  pcc_edge u_edge_d2 (
    .clock   (clock),
    .rst_b   (rst_b),
    .level   (third_port_pins[PCC_L_C2]),
    .rise_en (1'b0),
    .fall_en (1'b1),
    .pulse   (dig_pulse2)
  );

  // External interrupt requests: bit0 held low, bit1 line1, bit2 line2, bit3 line3
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ext_irq <= 4'h0;
    end else if (analog) begin
      ext_irq[0] <= 1'b0;
      ext_irq[1] <= one_pulse && irq_select[PCC_IRQ_E7 -: 2] != 2'b00; // RQ8 RQ14
      ext_irq[2] <= two_pulse; // RQ7
      ext_irq[3] <= 1'b0; // RQ6
    end else begin
      ext_irq[0] <= 1'b0;
      ext_irq[1] <= dig_pulse1;
      ext_irq[2] <= dig_pulse2;
      ext_irq[3] <= ref_pulse; // RQ6
    end
  end

  // Stop recovery sensing only in digital mode
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stop_wake <= 1'b0;
    end else begin
      stop_wake <= (power_mode == PCC_STOP) && !analog &&
                   (|(~third_port_pins[PCC_L_REF:PCC_L_TIN])); // RQ12
    end
  end

  // Timer input: comparator result in analog mode, raw pin otherwise
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timer_input <= 1'b0;
    end else begin
      timer_input <= analog ? first_comparator_result
                            : third_port_pins[PCC_L_TIN]; // RQ15
    end
  end

  always_comb begin
    next_pin_out = third_port_store;
    if (port_drive_configuration[PCC_PD_COMP_OUT]) begin
      next_pin_out[PCC_L_O4] = first_comparator_result; // RQ5
      next_pin_out[PCC_L_O5] = second_comparator_result;
      next_pin_out[PCC_L_O7] = second_comparator_result; // RQ10
    end
  end

  // Pin drive and configuration outputs, registered
  always_ff @(posedge clock) begin
    if (full_reset) begin
      third_port_out       <= 8'h00;
      third_port_oe_b      <= {~PCC_P3_DIR_RESET, PCC_P3_DIR_RESET}; // RQ3
      second_port_oe_b     <= PCC_SM_RESET; // RQ1
      second_port_pushpull <= 1'b0; // RQ1
      first_port_pushpull  <= 1'b1;
      port_zero_pushpull   <= 1'b1;
      port_std_drive       <= 4'hf;
      osc_std_drive        <= 1'b1;
      comparator_enable    <= 1'b0;
      analog_mode          <= 1'b0;
    end else begin
      third_port_out       <= next_pin_out;
      third_port_oe_b      <= {~PCC_P3_DIR_RESET, PCC_P3_DIR_RESET};
      second_port_oe_b     <= second_port_mode_register;
      second_port_pushpull <= third_port_mode_register[PCC_TM_P2_PUSHPULL]; // RQ16
      first_port_pushpull  <= port_drive_configuration[PCC_PD_P1_PUSHPULL]; // RQ18
      port_zero_pushpull   <= port_drive_configuration[PCC_PD_P0_PUSHPULL]; // RQ19
      port_std_drive       <= port_drive_configuration[PCC_PD_EMI_LO +: 4]; // RQ20
      osc_std_drive        <= port_drive_configuration[PCC_PD_OSC_STD]; // RQ21
      comparator_enable    <= comp_on; // RQ11
      analog_mode          <= analog; // RQ13
    end
  end

  // Data read: comparator results replace input bits 1 and 2 in analog mode
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == PCC_ADDR_THIRD_DATA) begin
      reg_rdata <= {third_port_store[7:4], third_port_pins[3],
                    analog ? second_comparator_result : third_port_pins[2],
                    analog ? first_comparator_result  : third_port_pins[1],
                    third_port_pins[0]}; // RQ9
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  routing_restore_a: assert property (@(posedge clock) disable iff (!rst_b)
    !port_drive_configuration[PCC_PD_COMP_OUT] |=> third_port_out[PCC_L_O4] == // RQ10
      $past(third_port_store[PCC_L_O4]))
    else $error("stored value not on line four");
  route_result_a: assert property (@(posedge clock) disable iff (!rst_b)
    port_drive_configuration[PCC_PD_COMP_OUT] |=> third_port_out[PCC_L_O7] == // RQ5
      $past(second_comparator_result))
    else $error("line seven not carrying comparator");
  ref_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
    analog_mode && $past(analog) |-> !ext_irq[3]) // RQ6
    else $error("reference line interrupted in analog mode");
  stop_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    power_mode == PCC_STOP |=> !comparator_enable) // RQ11
    else $error("comparator enabled in stop");
  stop_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
    analog |=> !stop_wake) // RQ12
    else $error("stop wake in analog mode");
  drive_reset_a: assert property (@(posedge clock)
    full_reset |=> port_drive_configuration == PCC_PD_RESET) // RQ23
    else $error("drive config reset value wrong");
  mode_keep_a: assert property (@(posedge clock)
    !rst_b && stop_recovery_reset |=> $stable(third_port_mode_register)) // RQ13
    else $error("mode lost over stop recovery");
  second_reset_a: assert property (@(posedge clock)
    full_reset |=> second_port_oe_b == PCC_SM_RESET && !second_port_pushpull) // RQ1
    else $error("second port reset wrong");
  halt_run_a: assert property (@(posedge clock) disable iff (!rst_b)
    analog && power_mode == PCC_HALT |=> comparator_enable) // RQ14
    else $error("comparator off in halt");

  // Edge sequences; the past reset term keeps a release cycle from faking an edge
  sequence one_rise_s;
    $past(rst_b) && analog && cmp_rise && first_comparator_result &&
      !$past(first_comparator_result);
  endsequence
  sequence two_fall_s;
    $past(rst_b) && analog && cmp_fall && !second_comparator_result &&
      $past(second_comparator_result);
  endsequence
  sequence ref_fall_s;
    $past(rst_b) && !analog && !third_port_pins[PCC_L_REF] &&
      $past(third_port_pins[PCC_L_REF]);
  endsequence
  one_rise_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ7
    one_rise_s ##1 (analog && irq_select[PCC_IRQ_E7 -: 2] != 2'b00) |=> ext_irq[1])
    else $error("line one rise gave no request");
  two_fall_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ8
    two_fall_s ##1 analog |=> ext_irq[2])
    else $error("line two fall gave no request");
  ref_fall_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ6
    ref_fall_s ##1 !analog |=> ext_irq[3])
    else $error("line three fall gave no request in digital mode");
  route_five_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ5
    port_drive_configuration[PCC_PD_COMP_OUT] |=> third_port_out[PCC_L_O5] ==
      $past(second_comparator_result))
    else $error("line five not carrying comparator");
  read_result_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ9
    reg_rd && reg_addr == PCC_ADDR_THIRD_DATA && analog |=> reg_rdata[PCC_L_TIN] ==
      $past(first_comparator_result))
    else $error("data read lacks first result");
  timer_in_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ15
    analog |=> timer_input == $past(first_comparator_result))
    else $error("timer input not following comparator");
  second_drive_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ16
    third_port_mode_register[PCC_TM_P2_PUSHPULL] |=> second_port_pushpull)
    else $error("second port not push-pull");
  wdt_recover_a: assert property (@(posedge clock) // RQ2
    !rst_b && stop_recovery_reset && wdt_timeout |=> $stable(port_drive_configuration))
    else $error("watchdog in stop recovery reset drive config");
  oe_fixed_a: assert property (@(posedge clock) disable iff (!rst_b) // RQ3
    third_port_oe_b == {~PCC_P3_DIR_RESET, PCC_P3_DIR_RESET})
    else $error("third port direction wrong");
endmodule

// File: tb/pcc_pins.sv
`timescale 1ns/1ps
module pcc_pins (
  input  wire logic       clock,
  input  wire logic [7:0] an_one,
  input  wire logic [7:0] an_two,
  input  wire logic [7:0] an_ref,
  input  wire logic [7:0] pin_lvl,
  output logic            comp_one_gt,
  output logic            comp_two_gt,
  output logic [7:0]      third_port_pins
);
  // Front ends settle one clock late, as a real comparator never answers instantly
  always_ff @(posedge clock) begin
    comp_one_gt <= an_one > an_ref;
    comp_two_gt <= an_two > an_ref;
  end
  assign third_port_pins = pin_lvl;
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pcc_pkg::*;
  logic          clock = 0, rst_b = 0, srr = 0, wdt = 0, wr = 0, rd = 0;
  logic [7:0]    addr = 0, wdata = 0, pin_lvl = 8'hff;
  logic [7:0]    an_one = 8'd20, an_two = 8'd20, an_ref = 8'd50;
  logic [3:0]    bank = 0;
  pcc_power_type pmode = PCC_RUN;
  logic          one_gt, two_gt, sp_pp, p1_pp, p0_pp, osc, cen, anm, wake, tin;
  logic [7:0]    pins, rdata, tp_out, tp_oe_b, sp_oe_b, rd_val;
  logic [3:0]    std_drv, irq;
  int            mismatches = 0, checks = 0, drv = 'hfe, mode = 0, stored = 0, c1, c2, c3;

  always #25 clock = ~clock;

  pcc_pins u_pins (.clock(clock), .an_one(an_one), .an_two(an_two), .an_ref(an_ref),
    .pin_lvl(pin_lvl), .comp_one_gt(one_gt), .comp_two_gt(two_gt), .third_port_pins(pins));

  pcc_ctrl u_dut (.clock(clock), .rst_b(rst_b), .stop_recovery_reset(srr),
    .wdt_timeout(wdt), .power_mode(pmode), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_bank(bank), .reg_wdata(wdata), .third_port_pins(pins), .comp_one_gt(one_gt),
    .comp_two_gt(two_gt), .reg_rdata(rdata), .third_port_out(tp_out),
    .third_port_oe_b(tp_oe_b), .second_port_oe_b(sp_oe_b), .second_port_pushpull(sp_pp),
    .first_port_pushpull(p1_pp), .port_zero_pushpull(p0_pp), .port_std_drive(std_drv),
    .osc_std_drive(osc), .comparator_enable(cen), .analog_mode(anm), .ext_irq(irq),
    .stop_wake(wake), .timer_input(tin));

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // The model follows accepted drive, third-mode and data writes, so later checks see its state
  task automatic wr_reg(logic [7:0] a, logic [3:0] b, logic [7:0] d);
    addr = a;
    bank = b;
    wdata = d;
    wr = 1;
    step(1);
    wr = 0;
    if (a == PCC_ADDR_PORT_DRIVE && b == PCC_BANK_PORT_DRIVE) drv = d;
    if (a == PCC_ADDR_THIRD_MODE) mode = d;
    if (a == PCC_ADDR_THIRD_DATA) stored = d;
    step(3);
  endtask

  task automatic rd_reg(logic [7:0] a);
    addr = a;
    rd = 1;
    step(1);
    rd_val = rdata;
    rd = 0;
    step(1);
  endtask

  task automatic cfg_chk();
    chk("port one drive", 8'(drv[1]), 8'(p1_pp));
    chk("port zero drive", 8'(drv[2]), 8'(p0_pp));
    chk("emission", 8'(drv[6:3]), 8'(std_drv));
    chk("osc drive", 8'(drv[7]), 8'(osc));
    chk("second drive", 8'(mode[0]), 8'(sp_pp));
  endtask

  task automatic watch(int e1, int e2, int e3);
    c1 = 0;
    c2 = 0;
    c3 = 0;
    repeat (10) begin
      @(posedge clock);
      #2;
      c1 += int'(irq[1] === 1'b1);
      c2 += int'(irq[2] === 1'b1);
      c3 += int'(irq[3] === 1'b1);
    end
    chk("irq line one", 8'(e1), 8'(c1));
    chk("irq line two", 8'(e2), 8'(c2));
    chk("irq line three", 8'(e3), 8'(c3));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h175b));
    step(20);
    rst_b = 1;
    chk("second oe_b", 8'hff, sp_oe_b);
    chk("third oe_b", 8'h0f, tp_oe_b);
    chk("analog", 8'h00, 8'(anm));
    cfg_chk();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(PCC_ADDR_PORT_DRIVE, PCC_BANK_PORT_DRIVE, 8'($urandom) & 8'hfe);
      cfg_chk();
    end
    wr_reg(PCC_ADDR_PORT_DRIVE, 4'h0, 8'h00);
    cfg_chk();
    rd_reg(PCC_ADDR_PORT_DRIVE);
    chk("drive read", 8'h00, rd_val);
    rd_reg(PCC_ADDR_THIRD_MODE);
    chk("mode read", 8'h00, rd_val);
    wr_reg(PCC_ADDR_SECOND_MODE, 4'h0, 8'h5a);
    chk("second oe_b", 8'h5a, sp_oe_b);
    $display("test drive config done");
    wr_reg(PCC_ADDR_THIRD_MODE, 4'h0, 8'h03);
    chk("analog", 8'h01, 8'(anm));
    chk("comp enable", 8'h01, 8'(cen));
    cfg_chk();
    an_one = 8'd80;
    step(5);
    rd_reg(PCC_ADDR_THIRD_DATA);
    chk("data bits", 8'h02, rd_val & 8'h06);
    chk("timer analog", 8'h01, 8'(tin));
    wr_reg(PCC_ADDR_THIRD_DATA, 4'h0, 8'h50);
    wr_reg(PCC_ADDR_PORT_DRIVE, PCC_BANK_PORT_DRIVE, 8'hff);
    chk("routed", 8'h10, tp_out & 8'hb0);
    an_one = 8'd20;
    an_two = 8'd80;
    step(5);
    chk("routed", 8'ha0, tp_out & 8'hb0);
    wr_reg(PCC_ADDR_PORT_DRIVE, PCC_BANK_PORT_DRIVE, 8'hfe);
    chk("stored", 8'(stored) & 8'hb0, tp_out & 8'hb0);
    $display("test routing done");
    for (int code = 0; code < 4; code++) begin
      an_two = 8'd20;
      step(8);
      wr_reg(PCC_ADDR_IRQ, 4'h0, 8'(code << 6));
      an_one = 8'd80;
      an_two = 8'd80;
      watch(code != 0, code != 0, 0);
      an_one = 8'd20;
      an_two = 8'd20;
      pin_lvl[3] = 0;
      watch(code == 3, code == 0 || code == 3, 0);
      pin_lvl[3] = 1;
    end
    pmode = PCC_HALT;
    an_two = 8'd80;
    watch(0, 1, 0);
    pmode = PCC_RUN;
    $display("test interrupts done");
    wr_reg(PCC_ADDR_THIRD_MODE, 4'h0, 8'h00);
    step(6);
    pin_lvl[3] = 0;
    watch(0, 0, 1);
    pin_lvl = 8'hfd;
    step(5);
    chk("timer digital", 8'h00, 8'(tin));
    pin_lvl = 8'hff;
    wr_reg(PCC_ADDR_THIRD_MODE, 4'h0, 8'h03);
    pmode = PCC_STOP;
    pin_lvl = 8'hf1;
    step(5);
    chk("comp enable", 8'h00, 8'(cen));
    chk("wake analog", 8'h00, 8'(wake));
    srr = 1;
    wdt = 1;
    rst_b = 0;
    step(3);
    rst_b = 1;
    srr = 0;
    wdt = 0;
    pmode = PCC_RUN;
    step(2);
    chk("analog kept", 8'h01, 8'(anm));
    chk("second oe_b kept", 8'h5a, sp_oe_b);
    cfg_chk();
    wr_reg(PCC_ADDR_THIRD_MODE, 4'h0, 8'h01);
    pmode = PCC_STOP;
    step(5);
    chk("wake digital", 8'h01, 8'(wake));
    pmode = PCC_RUN;
    pin_lvl = 8'hff;
    $display("test power modes done");
    summarize();
  end
endmodule
